// *** adcthr_chan.sv ***
// one channel of the threshold comparator: range and crossing status
// and the compare event for that channel.
// assumes hit is a one-cycle pulse with result and thresholds valid.
`timescale 1ns/1ns
module adcthr_chan (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        hit,
   input  wire logic [11:0] result,
   input  wire logic [11:0] low,
   input  wire logic [11:0] high,
   input  wire logic [1:0]  mode,
   output logic      [1:0]  range_r,
   output logic      [1:0]  cross_r,
   output logic             event_r
);
   logic [1:0] range_nxt;
   logic [1:0] cross_nxt;
   logic       event_nxt;
   logic       prev_below_r;
   logic       prev_below_nxt;
   logic       prev_valid_r;
   logic       prev_valid_nxt;
   logic       below;
   logic       above;
   logic       crossed;

   always_comb begin
      below          = result < low;
      above          = result > high;
      // the first result after reset has no predecessor to cross from
      crossed        = prev_valid_r && (prev_below_r != below);
      range_nxt      = range_r;
      cross_nxt      = cross_r;
      prev_below_nxt = prev_below_r;
      prev_valid_nxt = prev_valid_r;
      event_nxt      = 1'b0;
      if (hit) begin
         if (below) begin
            range_nxt = adcthr_pkg::RANGE_BELOW;
         end else if (above) begin
            range_nxt = adcthr_pkg::RANGE_ABOVE;
         end else begin
            range_nxt = adcthr_pkg::RANGE_IN;
         end
         if (crossed) begin
            cross_nxt = below ? adcthr_pkg::CROSS_DOWN
                              : adcthr_pkg::CROSS_UP;
         end else begin
            cross_nxt = adcthr_pkg::CROSS_NONE;
         end
         prev_below_nxt = below;
         prev_valid_nxt = 1'b1;
         event_nxt = ((mode == adcthr_pkg::MODE_OUTSIDE)
                      && (below || above))
                  || ((mode == adcthr_pkg::MODE_CROSS)
                      && crossed);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_r      <= adcthr_pkg::RANGE_IN;
         cross_r      <= adcthr_pkg::CROSS_NONE;
         event_r      <= 1'b0;
         prev_below_r <= 1'b0;
         prev_valid_r <= 1'b0;
      end else begin
         range_r      <= range_nxt;
         cross_r      <= cross_nxt;
         event_r      <= event_nxt;
         prev_below_r <= prev_below_nxt;
         prev_valid_r <= prev_valid_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // checker memory of the last sample's side of the low threshold, kept
   // apart from the datapath so a broken prev_below_r is still caught
   logic chk_seen_r;
   logic chk_seen_nxt;
   logic chk_was_below_r;
   logic chk_was_below_nxt;

   always_comb begin
      chk_seen_nxt      = chk_seen_r;
      chk_was_below_nxt = chk_was_below_r;
      if (hit) begin
         chk_seen_nxt      = 1'b1;
         chk_was_below_nxt = result < low;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_seen_r      <= 1'b0;
         chk_was_below_r <= 1'b0;
      end else begin
         chk_seen_r      <= chk_seen_nxt;
         chk_was_below_r <= chk_was_below_nxt;
      end
   end

   sequence s_after_below;
      chk_seen_r && chk_was_below_r;
   endsequence
   sequence s_after_clear;
      chk_seen_r && !chk_was_below_r;
   endsequence
   sequence s_below_sample;
      hit && (result < low);
   endsequence
   sequence s_clear_sample;
      hit && !(result < low);
   endsequence

   a_range_below: assert property (s_below_sample |=>
      range_r == adcthr_pkg::RANGE_BELOW)
      else $error("below result not flagged");
   a_range_above: assert property (
      hit && !(result < low) && (result > high) |=>
      range_r == adcthr_pkg::RANGE_ABOVE)
      else $error("above result not flagged");
   a_range_inside: assert property (
      hit && !(result < low) && !(result > high) |=>
      range_r == adcthr_pkg::RANGE_IN)
      else $error("in-range result not cleared");
   a_cross_up: assert property (
      s_after_below ##0 s_clear_sample |=>
      cross_r == adcthr_pkg::CROSS_UP)
      else $error("upward crossing missed");
   a_cross_down: assert property (
      s_after_clear ##0 s_below_sample |=>
      cross_r == adcthr_pkg::CROSS_DOWN)
      else $error("downward crossing missed");
   a_event_range: assert property (
      hit && (mode == adcthr_pkg::MODE_OUTSIDE)
      && ((result < low) || (result > high)) |=> event_r)
      else $error("out-of-range event missed");
   a_event_gate: assert property (
      hit && (mode == adcthr_pkg::MODE_OFF) |=> !event_r)
      else $error("event raised while disabled");
   a_event_mode3: assert property (
      hit && (mode == 2'h3) |=> !event_r)
      else $error("event raised in unused mode");
   a_cross_first: assert property (
      hit && !chk_seen_r |=> cross_r == adcthr_pkg::CROSS_NONE)
      else $error("crossing reported without a previous sample");
   a_cross_still: assert property (
      s_after_below ##0 s_below_sample |=>
      cross_r == adcthr_pkg::CROSS_NONE)
      else $error("crossing reported while staying below");
endmodule

// *** adcthr_conv_model.sv ***
// conversion engine stand-in: hands finished results to the comparator.
// assumes pclk from the bench; one result per call, one-cycle strobe.
`timescale 1ns/1ns
module adcthr_conv_model (
   input  wire logic        pclk,
   output logic             conv_valid,
   output logic      [3:0]  conv_chan,
   output logic      [11:0] conv_result
);
   initial begin
      conv_valid  = 1'b0;
      conv_chan   = 4'h0;
      conv_result = 12'h000;
   end
   task automatic conv(input logic [3:0] c, input logic [11:0] r);
      @(posedge pclk);
      conv_valid  <= 1'b1;
      conv_chan   <= c;
      conv_result <= r;
      @(posedge pclk);
      conv_valid  <= 1'b0;
      // idle lines carry junk so nothing can lean on stale values
      conv_chan   <= ~c;
      conv_result <= ~r;
   endtask
endmodule

// *** adcthr_pkg.sv ***
// package for the converter threshold comparator: register map,
// field layout, reset values and status codes.
// assumes a 32-bit apb slave; offsets are full byte addresses.
package adcthr_pkg;
   localparam int          NUM_CH       = 12;
   localparam int          RES_W        = 12;
   localparam int          THR_LSB      = 4;
   localparam int          THR_MSB      = 15;
   localparam int          MODE_W       = 2;

   localparam logic [31:0] OFF_LOW0     = 32'h4001c050;
   localparam logic [31:0] OFF_LOW1     = 32'h4001c054;
   localparam logic [31:0] OFF_HIGH0    = 32'h4001c058;
   localparam logic [31:0] OFF_HIGH1    = 32'h4001c05c;
   localparam logic [31:0] OFF_PAIR_SEL = 32'h4001c060;
   localparam logic [31:0] OFF_IRQ_MODE = 32'h4001c070;
   localparam logic [31:0] OFF_RANGE_ST = 32'h4001c074;
   localparam logic [31:0] OFF_CROSS_ST = 32'h4001c078;
   localparam logic [31:0] OFF_FLAGS    = 32'h4001c07c;
   localparam logic [31:0] OFF_MASK     = 32'h4001c080;

   localparam logic [11:0] RST_THR      = 12'h000;
   localparam logic [11:0] RST_PAIR_SEL = 12'h000;
   localparam logic [23:0] RST_IRQ_MODE = 24'h000000;
   localparam logic [11:0] RST_FLAGS    = 12'h000;
   localparam logic [11:0] RST_MASK     = 12'h000;

   localparam logic [1:0]  RANGE_IN     = 2'h0;
   localparam logic [1:0]  RANGE_BELOW  = 2'h1;
   localparam logic [1:0]  RANGE_ABOVE  = 2'h2;
   localparam logic [1:0]  CROSS_NONE   = 2'h0;
   localparam logic [1:0]  CROSS_DOWN   = 2'h2;
   localparam logic [1:0]  CROSS_UP     = 2'h3;
   localparam logic [1:0]  MODE_OFF     = 2'h0;
   localparam logic [1:0]  MODE_OUTSIDE = 2'h1;
   localparam logic [1:0]  MODE_CROSS   = 2'h2;
endpackage

// *** adcthr_top.sv ***
// threshold comparator for a 12-channel converter, with apb registers
// and one level interrupt.
// assumes conv_valid pulses once per finished conversion, synchronous
// to pclk, with conv_chan and conv_result valid in that cycle.
//
// Operation
// - channel bit clear uses pair 0 thresholds, set uses pair 1
// - result below selected low threshold sets range status 01
// - result above selected high threshold sets range status 10
// - successive results either side of low threshold flag a crossing
// - out-of-range result interrupts only when the channel allows it
// - crossing interrupts only when the channel enables crossing events
// - low threshold registers hold 12 bits at 15:4, reset zero
// - high threshold registers hold 12 bits at 15:4, reset zero
// - pair select has one bit per channel, reset zero
// - pair select reaches bit 11; higher bits unused
// - crossing status: 0 none, 2 downward, 3 upward
// - per-channel interrupt mode: off, out-of-range, or crossing
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module adcthr_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        conv_valid,
   input  wire logic [3:0]  conv_chan,
   input  wire logic [11:0] conv_result,
   output logic             irq
);
   localparam int N = adcthr_pkg::NUM_CH;

   logic [11:0] low0_r;
   logic [11:0] low0_nxt;
   logic [11:0] low1_r;
   logic [11:0] low1_nxt;
   logic [11:0] high0_r;
   logic [11:0] high0_nxt;
   logic [11:0] high1_r;
   logic [11:0] high1_nxt;
   logic [11:0] pair_sel_r;
   logic [11:0] pair_sel_nxt;
   logic [23:0] irq_mode_r;
   logic [23:0] irq_mode_nxt;
   logic [11:0] flags_r;
   logic [11:0] flags_nxt;
   logic [11:0] mask_r;
   logic [11:0] mask_nxt;
   logic [11:0] rdclr_r;
   logic [11:0] rdclr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        slverr_r;
   logic        slverr_nxt;

   logic        setup;
   logic        access;
   logic        wr_en;
   logic        mapped;
   logic [31:0] rd_mux;
   logic [23:0] range_all;
   logic [23:0] cross_all;
   logic [11:0] events;
   logic [11:0] thr_wdata;

   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign wr_en     = access && pwrite;
   // bits 3:0 and 31:16 are dropped; software is meant to write zero
   assign thr_wdata = pwdata[adcthr_pkg::THR_MSB:adcthr_pkg::THR_LSB];

   // ---- per-channel comparators
   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_ch
         logic        hit;
         logic [11:0] sel_low;
         logic [11:0] sel_high;
         assign hit      = conv_valid && (conv_chan == 4'(gi));
         assign sel_low  = pair_sel_r[gi] ? low1_r : low0_r;
         assign sel_high = pair_sel_r[gi] ? high1_r : high0_r;
         adcthr_chan u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .hit     (hit),
            .result  (conv_result),
            .low     (sel_low),
            .high    (sel_high),
            .mode    (irq_mode_r[2*gi+1:2*gi]),
            .range_r (range_all[2*gi+1:2*gi]),
            .cross_r (cross_all[2*gi+1:2*gi]),
            .event_r (events[gi])
         );
      end
   endgenerate

   // ---- read path: data is captured in the setup phase so that the
   // access phase can complete with no wait state
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      unique case (paddr)
         adcthr_pkg::OFF_LOW0: begin
            rd_mux[adcthr_pkg::THR_MSB:adcthr_pkg::THR_LSB] = low0_r;
         end
         adcthr_pkg::OFF_LOW1: begin
            rd_mux[adcthr_pkg::THR_MSB:adcthr_pkg::THR_LSB] = low1_r;
         end
         adcthr_pkg::OFF_HIGH0: begin
            rd_mux[adcthr_pkg::THR_MSB:adcthr_pkg::THR_LSB] = high0_r;
         end
         adcthr_pkg::OFF_HIGH1: begin
            rd_mux[adcthr_pkg::THR_MSB:adcthr_pkg::THR_LSB] = high1_r;
         end
         adcthr_pkg::OFF_PAIR_SEL: begin
            rd_mux[11:0] = pair_sel_r;
         end
         adcthr_pkg::OFF_IRQ_MODE: begin
            rd_mux[23:0] = irq_mode_r;
         end
         adcthr_pkg::OFF_RANGE_ST: begin
            rd_mux[23:0] = range_all;
         end
         adcthr_pkg::OFF_CROSS_ST: begin
            rd_mux[23:0] = cross_all;
         end
         adcthr_pkg::OFF_FLAGS: begin
            rd_mux[11:0] = flags_r;
         end
         adcthr_pkg::OFF_MASK: begin
            rd_mux[11:0] = mask_r;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      prdata_nxt = prdata_r;
      slverr_nxt = slverr_r;
      rdclr_nxt  = rdclr_r;
      if (setup) begin
         prdata_nxt = pwrite ? 32'h00000000 : rd_mux;
         slverr_nxt = !mapped;
         // only the flags that software actually sees are cleared later
         rdclr_nxt  = (!pwrite && (paddr == adcthr_pkg::OFF_FLAGS))
                      ? flags_r : 12'h000;
      end
   end

   // ---- configuration registers
   always_comb begin
      low0_nxt     = low0_r;
      low1_nxt     = low1_r;
      high0_nxt    = high0_r;
      high1_nxt    = high1_r;
      pair_sel_nxt = pair_sel_r;
      irq_mode_nxt = irq_mode_r;
      mask_nxt     = mask_r;
      if (wr_en) begin
         unique case (paddr)
            adcthr_pkg::OFF_LOW0:     low0_nxt     = thr_wdata;
            adcthr_pkg::OFF_LOW1:     low1_nxt     = thr_wdata;
            adcthr_pkg::OFF_HIGH0:    high0_nxt    = thr_wdata;
            adcthr_pkg::OFF_HIGH1:    high1_nxt    = thr_wdata;
            adcthr_pkg::OFF_PAIR_SEL: pair_sel_nxt = pwdata[11:0];
            adcthr_pkg::OFF_IRQ_MODE: irq_mode_nxt = pwdata[23:0];
            adcthr_pkg::OFF_MASK:     mask_nxt     = pwdata[11:0];
            default: begin
            end
         endcase
      end
   end

   // ---- sticky compare flags: a new event wins over the read clear
   always_comb begin
      flags_nxt = flags_r;
      if (access && !pwrite && (paddr == adcthr_pkg::OFF_FLAGS)) begin
         flags_nxt = flags_r & ~rdclr_r;
      end
      flags_nxt = flags_nxt | events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low0_r     <= adcthr_pkg::RST_THR;
         low1_r     <= adcthr_pkg::RST_THR;
         high0_r    <= adcthr_pkg::RST_THR;
         high1_r    <= adcthr_pkg::RST_THR;
         pair_sel_r <= adcthr_pkg::RST_PAIR_SEL;
         irq_mode_r <= adcthr_pkg::RST_IRQ_MODE;
         mask_r     <= adcthr_pkg::RST_MASK;
         flags_r    <= adcthr_pkg::RST_FLAGS;
         rdclr_r    <= 12'h000;
         prdata_r   <= 32'h00000000;
         slverr_r   <= 1'b0;
      end else begin
         low0_r     <= low0_nxt;
         low1_r     <= low1_nxt;
         high0_r    <= high0_nxt;
         high1_r    <= high1_nxt;
         pair_sel_r <= pair_sel_nxt;
         irq_mode_r <= irq_mode_nxt;
         mask_r     <= mask_nxt;
         flags_r    <= flags_nxt;
         rdclr_r    <= rdclr_nxt;
         prdata_r   <= prdata_nxt;
         slverr_r   <= slverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = access && slverr_r;
   assign irq     = |(flags_r & mask_r);

   // ---- checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wr_low0;
      wr_en && (paddr == adcthr_pkg::OFF_LOW0);
   endsequence
   sequence s_rd_setup_low0;
      setup && !pwrite && (paddr == adcthr_pkg::OFF_LOW0);
   endsequence

   // a conversion that the comparator must take
   sequence s_conv_ok;
      conv_valid && (conv_chan < 4'hc);
   endsequence

   // ---- register file
   a_thr_store: assert property (
      s_wr_low0 ##[1:2] s_rd_setup_low0 |=>
      prdata[15:4] == $past(low0_r) && prdata[3:0] == 4'h0)
      else $error("low threshold readback wrong");
   a_high_store: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_HIGH1) |=>
      high1_r == $past(pwdata[15:4]))
      else $error("high threshold not stored");
   a_sel_width: assert property (
      setup && !pwrite && (paddr == adcthr_pkg::OFF_PAIR_SEL) |=>
      prdata[31:12] == 20'h00000)
      else $error("pair select upper bits not zero");
   a_pair_route: assert property (
      conv_valid && (conv_chan < 4'hc) && pair_sel_r[conv_chan]
      && (conv_result < low1_r) |=>
      range_all[2*$past(conv_chan)+:2] == adcthr_pkg::RANGE_BELOW)
      else $error("pair 1 threshold not used");
   a_flag_keep: assert property (
      |(events & mask_r) |=> irq ##0 (flags_r & $past(events)) ==
      $past(events))
      else $error("compare event lost");
   a_read_clear: assert property (
      access && !pwrite && (paddr == adcthr_pkg::OFF_FLAGS)
      && (events == 12'h000) |=> (flags_r & $past(rdclr_r)) == 12'h000)
      else $error("flags not cleared by read");
   a_low0_store: assert property (
      s_wr_low0 |=> low0_r == $past(pwdata[15:4]))
      else $error("low threshold 0 not stored");
   a_low1_store: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_LOW1) |=>
      low1_r == $past(pwdata[15:4]))
      else $error("low threshold 1 not stored");
   a_rd_low1: assert property (
      setup && !pwrite && (paddr == adcthr_pkg::OFF_LOW1) |=>
      prdata[15:4] == $past(low1_r))
      else $error("low threshold 1 readback wrong");
   a_high0_store: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_HIGH0) |=>
      high0_r == $past(pwdata[15:4]))
      else $error("high threshold 0 not stored");
   a_rd_high1: assert property (
      setup && !pwrite && (paddr == adcthr_pkg::OFF_HIGH1) |=>
      prdata[15:4] == $past(high1_r))
      else $error("high threshold 1 readback wrong");
   a_thr_lanes: assert property (
      setup && !pwrite && (paddr == adcthr_pkg::OFF_HIGH0) |=>
      prdata[31:16] == 16'h0000 && prdata[3:0] == 4'h0)
      else $error("threshold reserved bits not zero");
   a_sel_store: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_PAIR_SEL) |=>
      pair_sel_r == $past(pwdata[11:0]))
      else $error("pair select not stored");
   a_sel_hold: assert property (
      !(wr_en && (paddr == adcthr_pkg::OFF_PAIR_SEL)) |=>
      $stable(pair_sel_r))
      else $error("pair select changed without a write");
   a_mode_store: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_IRQ_MODE) |=>
      irq_mode_r == $past(pwdata[23:0]))
      else $error("interrupt mode not stored");

   // ---- comparator routing
   a_pair0_low: assert property (
      s_conv_ok ##0 (!pair_sel_r[conv_chan] && (conv_result < low0_r)) |=>
      range_all[2*$past(conv_chan)+:2] == adcthr_pkg::RANGE_BELOW)
      else $error("pair 0 low threshold not used");
   a_pair0_high: assert property (
      s_conv_ok ##0 (!pair_sel_r[conv_chan] && (conv_result >= low0_r)
      && (conv_result > high0_r)) |=>
      range_all[2*$past(conv_chan)+:2] == adcthr_pkg::RANGE_ABOVE)
      else $error("pair 0 high threshold not used");
   a_pair1_high: assert property (
      s_conv_ok ##0 (pair_sel_r[conv_chan] && (conv_result >= low1_r)
      && (conv_result > high1_r)) |=>
      range_all[2*$past(conv_chan)+:2] == adcthr_pkg::RANGE_ABOVE)
      else $error("pair 1 high threshold not used");
   a_mode_off: assert property (
      s_conv_ok ##0 (irq_mode_r[2*conv_chan+:2] == adcthr_pkg::MODE_OFF)
      |=> !events[$past(conv_chan)])
      else $error("event raised on a disabled channel");
   a_status_ro: assert property (
      wr_en && (paddr == adcthr_pkg::OFF_RANGE_ST) && !conv_valid |=>
      range_all == $past(range_all))
      else $error("range status changed by a write");

   // ---- flags and interrupt
   a_flag_hold: assert property (
      !(access && !pwrite && (paddr == adcthr_pkg::OFF_FLAGS)) |=>
      (flags_r & $past(flags_r)) == $past(flags_r))
      else $error("compare flag lost without a read");
   a_flag_cause: assert property (
      1'b1 |=> (flags_r & ~$past(flags_r) & ~$past(events)) == 12'h000)
      else $error("compare flag set without an event");
   a_flag_read: assert property (
      setup && !pwrite && (paddr == adcthr_pkg::OFF_FLAGS) |=>
      prdata[11:0] == $past(flags_r))
      else $error("flags readback wrong");
   a_irq_gate: assert property (
      (flags_r & mask_r) == 12'h000 |-> !irq)
      else $error("interrupt without an unmasked flag");
endmodule

// *** adcthr_top_tb_top.sv ***
// self-checking bench for the threshold comparator.
// assumes a zero-wait apb slave and the conversion model beside it.
`timescale 1ns/1ns
module adcthr_top_tb_top;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, q;
   logic        pready, pslverr, irq, e;
   logic        conv_valid;
   logic [3:0]  conv_chan;
   logic [11:0] conv_result;
   int          n_fail, num_checks, cyc;

   adcthr_top i_adcthr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_valid(conv_valid),
      .conv_chan(conv_chan), .conv_result(conv_result), .irq(irq));
   adcthr_conv_model i_adcthr_conv_model (.pclk(pclk),
      .conv_valid(conv_valid), .conv_chan(conv_chan),
      .conv_result(conv_result));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask

   task chk_irq(input logic x);
      #1;
      chk({31'h0, irq}, {31'h0, x});
   endtask

   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         report_and_stop;
      end
   endtask

   // field-only compare: reserved positions read back zero but are masked off here
   task rd(input logic [31:0] a, input logic [31:0] x,
           input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
      chk({31'h0, e}, 32'h0);
   endtask

   task t_regs;
      logic [31:0] ad [5];
      ad = '{adcthr_pkg::OFF_LOW0, adcthr_pkg::OFF_LOW1,
             adcthr_pkg::OFF_HIGH0, adcthr_pkg::OFF_HIGH1,
             adcthr_pkg::OFF_PAIR_SEL};
      for (int i = 0; i < 4; i++) begin
         rd(ad[i], 32'h0, 32'h0000fff0);
         apb(1'b1, ad[i], 32'h0000a5f0 ^ (i << 4));
         rd(ad[i], 32'h0000a5f0 ^ (i << 4), 32'h0000fff0);
      end
      rd(ad[4], 32'h0, 32'h00000fff);
      apb(1'b1, ad[4], 32'h00000fff);
      rd(ad[4], 32'h00000fff, 32'h00000fff);
      apb(1'b0, 32'h4001c000, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask

   task t_range;
      logic [3:0]  c [10];
      logic [11:0] r [10];
      logic [1:0]  x [10];
      c = '{0, 0, 0, 0, 1, 1, 1, 0, 0, 11};
      r = '{12'h0ff, 12'h100, 12'h800, 12'h801, 12'h3ff,
            12'h900, 12'hc01, 12'h3ff, 12'h900, 12'h3ff};
      x = '{1, 0, 0, 2, 1, 0, 2, 0, 2, 1};
      apb(1'b1, adcthr_pkg::OFF_LOW0, 32'h00001000);
      apb(1'b1, adcthr_pkg::OFF_HIGH0, 32'h00008000);
      apb(1'b1, adcthr_pkg::OFF_LOW1, 32'h00004000);
      apb(1'b1, adcthr_pkg::OFF_HIGH1, 32'h0000c000);
      apb(1'b1, adcthr_pkg::OFF_PAIR_SEL, 32'h00000802);
      for (int i = 0; i < 10; i++) begin
         i_adcthr_conv_model.conv(c[i], r[i]);
         rd(adcthr_pkg::OFF_RANGE_ST, {30'h0, x[i]} << (2 * c[i]),
            32'h3 << (2 * c[i]));
      end
      // status is read-only: a write must leave the last results
      apb(1'b1, adcthr_pkg::OFF_RANGE_ST, 32'hffffffff);
      rd(adcthr_pkg::OFF_RANGE_ST, 32'h0040000a,
         32'h00ffffff);
   endtask

   task t_cross;
      logic [11:0] r [5];
      logic [1:0]  x [5];
      r = '{12'h200, 12'h0ff, 12'h0f0, 12'h100, 12'h7ff};
      x = '{0, 2, 0, 3, 0};
      for (int i = 0; i < 5; i++) begin
         i_adcthr_conv_model.conv(4'h2, r[i]);
         rd(adcthr_pkg::OFF_CROSS_ST, {26'h0, x[i], 4'h0},
            32'h00000030);
      end
   endtask

   task settle_flag(input logic [3:0] ch, input logic x);
      repeat (3) @(posedge pclk);
      chk_irq(x);
      rd(adcthr_pkg::OFF_FLAGS, {31'h0, x} << ch, 32'h00000fff);
      chk_irq(1'b0);
   endtask

   // channels 3 to 6 get modes 0 to 3; mode 3 must behave as off
   task t_irq;
      apb(1'b1, adcthr_pkg::OFF_IRQ_MODE, 32'h00003900);
      apb(1'b1, adcthr_pkg::OFF_MASK, 32'h00000fff);
      for (int i = 0; i < 4; i++) begin
         i_adcthr_conv_model.conv(3 + i, 12'h200);
         i_adcthr_conv_model.conv(3 + i, 12'h900);
         settle_flag(3 + i, i == 1);
         i_adcthr_conv_model.conv(3 + i, 12'h050);
         settle_flag(3 + i, i == 1 || i == 2);
      end
      apb(1'b1, adcthr_pkg::OFF_MASK, 32'h0);
      i_adcthr_conv_model.conv(4'h4, 12'h900);
      repeat (3) @(posedge pclk);
      chk_irq(1'b0);
      rd(adcthr_pkg::OFF_FLAGS, 32'h00000010, 32'h00000fff);
   endtask

   initial begin
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_range;
      t_cross;
      t_irq;
      report_and_stop;
   end
endmodule
